// ==== nsx_pkg.sv ====
// nsx_pkg: opcode encodings, field positions, reset values and file-map addresses.
// assumes a 14-bit instruction word and an 8-bit data path.
package nsx_pkg;
  // ==========================================
  // opcode patterns
  localparam int NSX_IW = 14;
  localparam logic [5:0] NSX_SWAP_HI = 6'h0E;
  localparam logic [5:0] NSX_XORF_HI = 6'h06;
  localparam logic [5:0] NSX_XORL_HI = 6'h3A;
  localparam logic [10:0] NSX_DIRL_HI = 11'h00C;
  // ==========================================
  // field positions
  localparam int NSX_D_BIT = 7;
  localparam int NSX_F_MSB = 6;
  localparam int NSX_K_MSB = 7;
  localparam int NSX_SEL_MSB = 2;
  // ==========================================
  // direction register selection and file addresses
  localparam logic [2:0] NSX_DIR_FIRST = 3'h5;
  localparam logic [2:0] NSX_DIR_LAST = 3'h7;
  localparam logic [6:0] NSX_DIR_ADDR0 = 7'h05;
  localparam int NSX_NDIR = 3;
  // ==========================================
  // reset values
  localparam logic [7:0] NSX_W_RST = 8'h00;
  localparam logic [7:0] NSX_DIR_RST = 8'hFF;
  localparam logic [7:0] NSX_FILE_RST = 8'h00;
  typedef enum logic [1:0] {
    NSX_OP_NONE = 2'b00,
    NSX_OP_SWAP = 2'b01,
    NSX_OP_XORF = 2'b10,
    NSX_OP_XORL = 2'b11
  } nsx_op_t;
endpackage

// ==== nsx_dec_if.sv ====
// nsx_dec_if: decoded instruction fields passed from decoder to executor.
// assumes a single clock domain.
`timescale 1ns/1ps
`default_nettype none
interface nsx_dec_if;
  import nsx_pkg::*;
  logic valid;
  nsx_op_t op;
  logic dirl;
  logic dest_f;
  logic [6:0] faddr;
  logic [7:0] lit;
  logic [2:0] sel;
  modport dec (output valid, op, dirl, dest_f, faddr, lit, sel);
  modport exe (input valid, op, dirl, dest_f, faddr, lit, sel);
endinterface
`default_nettype wire

// ==== nsx_decode.sv ====
// nsx_decode: combinational split of one instruction word into fields.
// assumes instr is stable while instr_valid is high.
`timescale 1ns/1ps
`default_nettype none
module nsx_decode
  import nsx_pkg::*;
(
  input wire logic [NSX_IW-1:0] instr,
  input wire logic instr_valid,
  nsx_dec_if.dec d
);
  // ==========================================
  // opcode match
  always_comb begin
    d.op = NSX_OP_NONE;
    if (instr[13:8] == NSX_SWAP_HI) begin
      d.op = NSX_OP_SWAP;
    end else if (instr[13:8] == NSX_XORF_HI) begin
      d.op = NSX_OP_XORF;
    end else if (instr[13:8] == NSX_XORL_HI) begin
      d.op = NSX_OP_XORL;
    end
  end
  // selector outside five to seven is not a direction load
  assign d.dirl = (instr[13:3] == NSX_DIRL_HI) && (instr[2:0] >= NSX_DIR_FIRST);
  assign d.valid = instr_valid;
  assign d.dest_f = instr[NSX_D_BIT];
  assign d.faddr = instr[NSX_F_MSB:0];
  assign d.lit = instr[NSX_K_MSB:0];
  assign d.sel = instr[NSX_SEL_MSB:0];
endmodule
`default_nettype wire

// ==== nsx_exec.sv ====
// nsx_exec: executes nibble swap, both exclusive-ors and direction load.
// assumes one instruction per clock and a 128-entry file held here.
// Notes on behaviour
// - nibble swap exchanges the two halves of the file register and leaves flags alone.
// - nibble swap result goes to the working register when d is 0, else to the file.
// - direction load copies the working register into direction register 5, 6 or 7.
// - each direction register is also reachable as an ordinary file register.
// - literal exclusive-or combines the working register with k into the working register.
// - register exclusive-or combines the working register with file register 0 to 127.
// - register exclusive-or result goes to the working register when d is 0, else the file.
`timescale 1ns/1ps
`default_nettype none
module nsx_exec
  import nsx_pkg::*;
#(
  parameter int DEPTH = 128
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [NSX_IW-1:0] instr,
  input wire logic instr_valid,
  output logic [7:0] w_ff,
  output logic zero_ff,
  output logic [7:0] dir_out_ff [NSX_NDIR],
  output logic done_ff
);
  nsx_dec_if d ();
  nsx_decode u_dec (
    .instr(instr),
    .instr_valid(instr_valid),
    .d(d)
  );
  logic [7:0] file_ff [DEPTH];
  logic [7:0] fval;
  logic [7:0] nxt_res;
  logic wr_w;
  logic wr_f;
  logic sets_z;
  // ==========================================
  // direction address decode
  function automatic logic is_dir(input logic [6:0] a);
    return (a >= NSX_DIR_ADDR0) && (a < NSX_DIR_ADDR0 + 7'(NSX_NDIR));
  endfunction
  // ==========================================
  // operand and result
  always_comb begin
    fval = file_ff[d.faddr];
    nxt_res = 8'h00;
    wr_w = 1'b0;
    wr_f = 1'b0;
    sets_z = 1'b0;
    if (d.valid) begin
      unique case (d.op)
        NSX_OP_SWAP: begin
          nxt_res = {fval[3:0], fval[7:4]};
          wr_w = !d.dest_f;
          wr_f = d.dest_f;
        end
        NSX_OP_XORF: begin
          nxt_res = w_ff ^ fval;
          wr_w = !d.dest_f;
          wr_f = d.dest_f;
          sets_z = 1'b1;
        end
        NSX_OP_XORL: begin
          nxt_res = w_ff ^ d.lit;
          wr_w = 1'b1;
          sets_z = 1'b1;
        end
        NSX_OP_NONE: begin
          nxt_res = 8'h00;
        end
      endcase
    end
  end
  // ==========================================
  // working register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      w_ff <= NSX_W_RST;
    end else if (wr_w) begin
      w_ff <= nxt_res;
    end
  end
  // ==========================================
  // zero flag, only the exclusive-ors touch it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_ff <= 1'b0;
    end else if (sets_z) begin
      zero_ff <= (nxt_res == 8'h00);
    end
  end
  // ==========================================
  // file registers, direction registers included
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_file
      localparam logic [6:0] ADDR = 7'(gi);
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          file_ff[gi] <= is_dir(ADDR) ? NSX_DIR_RST : NSX_FILE_RST;
        end else if (d.valid && d.dirl && is_dir(ADDR) && (7'(d.sel) == ADDR)) begin
          file_ff[gi] <= w_ff;
        end else if (wr_f && (d.faddr == ADDR)) begin
          file_ff[gi] <= nxt_res;
        end
      end
    end
    for (gi = 0; gi < NSX_NDIR; gi++) begin : g_dir
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dir_out_ff[gi] <= NSX_DIR_RST;
        end else begin
          dir_out_ff[gi] <= file_ff[NSX_DIR_ADDR0 + gi];
        end
      end
    end
  endgenerate
  // ==========================================
  // completion pulse one cycle after each valid instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= d.valid;
    end
  end
  // ==========================================
  // assertions
  logic [7:0] swp_exp;
  logic [7:0] xf_exp;
  assign swp_exp = {fval[3:0], fval[7:4]};
  assign xf_exp = w_ff ^ fval;
  property p_swap_w;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_SWAP && !d.dest_f) |=> (w_ff == $past(swp_exp));
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap to w wrong");
  property p_swap_noz;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_SWAP) |=> $stable(zero_ff);
  endproperty
  a_swap_noz: assert property (p_swap_noz) else $error("swap changed zero");
  property p_swap_f;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_SWAP && d.dest_f) |=> $stable(w_ff);
  endproperty
  a_swap_f: assert property (p_swap_f) else $error("swap to f touched w");
  property p_dirl;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.dirl && d.sel == NSX_DIR_LAST) |=> ##1 (dir_out_ff[2] == $past(w_ff, 2));
  endproperty
  a_dirl: assert property (p_dirl) else $error("direction load lost");
  property p_dirf;
    @(posedge clk) disable iff (!rst_n)
      (wr_f && d.faddr == NSX_DIR_ADDR0 && !d.dirl) |=> ##1 (dir_out_ff[0] == $past(nxt_res, 2));
  endproperty
  a_dirf: assert property (p_dirf) else $error("direction file write lost");
  property p_xorl;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_XORL) |=> (w_ff == ($past(w_ff) ^ $past(d.lit)));
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor wrong");
  property p_xorf;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_XORF && !d.dest_f) |=> (w_ff == $past(xf_exp));
  endproperty
  a_xorf: assert property (p_xorf) else $error("register xor to w wrong");
  property p_xorf_f;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_XORF && d.dest_f) |=> $stable(w_ff);
  endproperty
  a_xorf_f: assert property (p_xorf_f) else $error("register xor to f touched w");
  property p_zero;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op inside {NSX_OP_XORL, NSX_OP_XORF}) |=>
        (zero_ff == ($past(nxt_res) == 8'h00));
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_done;
    @(posedge clk) disable iff (!rst_n)
      d.valid |=> done_ff;
  endproperty
  a_done: assert property (p_done) else $error("instruction took more than one cycle");
  property p_done_idle;
    @(posedge clk) disable iff (!rst_n)
      !d.valid |=> !done_ff;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("completion without instruction");
  // file write-back of both read-modify opcodes
  property p_swap_fw;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_SWAP && d.dest_f) |=>
        (file_ff[$past(d.faddr)] == $past(swp_exp));
  endproperty
  a_swap_fw: assert property (p_swap_fw) else $error("swap to f wrong");
  property p_xorf_fw;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_XORF && d.dest_f) |=>
        (file_ff[$past(d.faddr)] == $past(xf_exp));
  endproperty
  a_xorf_fw: assert property (p_xorf_fw) else $error("register xor to f wrong");
  // direction load lands in the selected register and leaves w and flags alone
  property p_dirl_file;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.dirl) |=>
        (file_ff[NSX_DIR_ADDR0 + 7'($past(d.sel) - NSX_DIR_FIRST)] == $past(w_ff));
  endproperty
  a_dirl_file: assert property (p_dirl_file) else $error("direction load wrong target");
  property p_dirl_flags;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.dirl) |=> ($stable(w_ff) && $stable(zero_ff));
  endproperty
  a_dirl_flags: assert property (p_dirl_flags) else $error("direction load touched w");
  // selector below five must not write the file register that the selector names
  property p_refuse;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && instr[13:3] == NSX_DIRL_HI && !d.dirl) |=>
        (file_ff[$past(d.sel)] == $past(file_ff[d.sel]));
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused direction load wrote");
  property p_none_keep;
    @(posedge clk) disable iff (!rst_n)
      (d.valid && d.op == NSX_OP_NONE) |=> ($stable(w_ff) && $stable(zero_ff));
  endproperty
  a_none_keep: assert property (p_none_keep) else $error("no-op changed w or zero");
  c_swap: cover property (@(posedge clk) disable iff (!rst_n) d.valid && d.op == NSX_OP_SWAP);
  c_xorz: cover property (@(posedge clk) disable iff (!rst_n) sets_z && nxt_res == 8'h00);
  c_dirl: cover property (@(posedge clk) disable iff (!rst_n) d.valid && d.dirl);
  c_xorf: cover property (@(posedge clk) disable iff (!rst_n)
    d.valid && d.op == NSX_OP_XORF && d.dest_f);
  c_refuse: cover property (@(posedge clk) disable iff (!rst_n)
    d.valid && instr[13:3] == NSX_DIRL_HI && !d.dirl);
endmodule
`default_nettype wire

// ==== nsx_exec_tb.sv ====
// nsx_exec_tb: self-checking bench for the four-opcode executor.
// assumes nsx_pkg and the design files are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb
  import nsx_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [NSX_IW-1:0] instr = 14'h0000;
  logic [7:0] w_ff;
  logic zero_ff;
  logic done_ff;
  logic [7:0] dir_out_ff [NSX_NDIR];
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] mw;
  logic mz;
  logic [7:0] mf [128];

  nsx_exec u_nsx_exec (.clk(clk), .rst_n(rst_n), .instr(instr), .instr_valid(instr_valid),
    .w_ff(w_ff), .zero_ff(zero_ff), .dir_out_ff(dir_out_ff), .done_ff(done_ff));

  initial begin
    forever #25 clk = ~clk;
  end

  // ==========================================
  // helpers
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task chk_wz;
    chk("w", w_ff, mw);
    chk("zero", {7'h00, zero_ff}, {7'h00, mz});
  endtask
  task op(input logic [NSX_IW-1:0] i);
    instr = i;
    instr_valid = 1'b1;
    @(posedge clk);
    #1;
    chk("done", {7'h00, done_ff}, 8'h01);
  endtask
  task idle;
    instr_valid = 1'b0;
    @(posedge clk);
    #1;
    chk("done_idle", {7'h00, done_ff}, 8'h00);
  endtask
  task xl(input logic [7:0] k);
    op({NSX_XORL_HI, k});
    mw = mw ^ k;
    mz = (mw == 8'h00);
  endtask
  task xf(input logic [6:0] f, input logic d);
    logic [7:0] r;
    r = mw ^ mf[f];
    op({NSX_XORF_HI, d, f});
    mz = (r == 8'h00);
    if (d) mf[f] = r;
    else mw = r;
  endtask
  task sw(input logic [6:0] f, input logic d);
    logic [7:0] r;
    r = {mf[f][3:0], mf[f][7:4]};
    op({NSX_SWAP_HI, d, f});
    if (d) mf[f] = r;
    else mw = r;
  endtask
  task dl(input logic [2:0] s);
    op({NSX_DIRL_HI, s});
    if (s >= NSX_DIR_FIRST) mf[s] = mw;
  endtask
  task chk_dir;
    for (int i = 0; i < NSX_NDIR; i++) begin
      chk("dir", dir_out_ff[i], mf[NSX_DIR_ADDR0 + i]);
    end
  endtask

  // ==========================================
  // scenarios
  task t_reset;
    mw = NSX_W_RST;
    mz = 1'b0;
    for (int i = 0; i < 128; i++) mf[i] = NSX_FILE_RST;
    for (int i = 0; i < NSX_NDIR; i++) mf[NSX_DIR_ADDR0 + i] = NSX_DIR_RST;
    chk_wz();
    chk_dir();
  endtask
  task t_xor_lit;
    xl(8'hB5);
    chk_wz();
    xl(8'hAF);
    chk("w_walk", w_ff, 8'h1A);
    xl(8'h1A);
    chk_wz();
    idle();
  endtask
  task t_xor_reg;
    xl(8'hB5);
    xf(7'h7F, 1'b1);
    chk_wz();
    xf(7'h7F, 1'b0);
    chk_wz();
    xl(8'h1A);
    xf(7'h00, 1'b1);
    xf(7'h00, 1'b0);
    chk_wz();
    xl(8'hB5);
    xf(7'h00, 1'b0);
    chk_wz();
    idle();
  endtask
  task t_swap;
    xl(mw);
    sw(7'h00, 1'b0);
    chk_wz();
    sw(7'h00, 1'b1);
    chk_wz();
    sw(7'h00, 1'b0);
    chk_wz();
    idle();
  endtask
  task t_dirl;
    xl(8'h3C);
    dl(3'h4);
    sw(7'h04, 1'b0);
    chk_wz();
    for (logic [3:0] s = 4'h5; s < 4'h8; s++) begin
      xl({4'h0, s});
      dl(s[2:0]);
    end
    idle();
    idle();
    chk_dir();
    sw(7'h05, 1'b0);
    chk_wz();
    xf(7'h06, 1'b1);
    sw(7'h05, 1'b1);
    idle();
    idle();
    chk("dir_file", dir_out_ff[1], mf[6]);
    chk("dir_swap", dir_out_ff[0], mf[5]);
  endtask

  // ==========================================
  // run control
  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    forever begin
      @(posedge clk);
      cycles++;
      if (cycles >= 2000) begin
        mismatches++;
        tally_and_finish();
      end
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_xor_lit();
    t_xor_reg();
    t_swap();
    t_dirl();
    tally_and_finish();
  end
endmodule
`default_nettype wire
